// ### arith_element_decode_ctrl.sv
// decode, register load and pause control for the arithmetic extension
// Contract
// - extension word needs buffer bits 00..03 and 11 all ones
// - register-load: some bit 04..07 set, 08..10 clear; step load also
// - arithmetic op: 04..07 clear, some 08..10 set; two cycles except normalize (one), pause
// - several non-conflicting micro-operations in one word execute together
// - all ops except normalize use an execute cycle for the operand
// - hold processor during an arithmetic op, at least 7.8 us
// - finish sets done flag, which sets time state four, ending hold
// - op register loads bits 08,09,10 into bits 0,1,2 at fetch pulse
// - instruction strobe needs fetch, operate, bits 03 and 11; gated by pulse
// - 12-bit multiplier-quotient register shifts both ways, extends accumulator
// - multiply/divide leave product low half or quotient in mq
// - step counter takes complement of bits 07..11 or clears per op
// - step counter counts shifts and stops shifting when done
// - transfers run in fetch: sequence one, pulse three, then after
// - clear_acc clears accumulator in sequence one, combinable with loads
// - buffer bit 04 inhibits accumulator gate, zeroing the load
// - accumulator load strobe on pulse three of every operate fetch
// - clear_acc_and_mq also clears mq at pulse three
// - mq_to_acc ors mq into accumulator at pulse three
// - acc_to_mq copies accumulator into mq and clears accumulator
// - stepcount_to_acc ors step counter into accumulator
module arith_element_decode_ctrl (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // processor timing and instruction word
  input  wire logic        fetch_state,
  input  wire logic        execute_state,
  input  wire logic        operate_class,
  input  wire logic        operate_phase_two,
  input  wire logic        time_pulse_three,
  input  wire logic [0:11] memory_buffer_bits,
  input  wire logic [0:11] accumulator,
  // result of the external multiply/divide datapath
  input  wire logic [0:11] muldiv_mq_result,
  // accumulator load path
  output logic             acc_load_strobe,
  output logic             acc_gate_enable,
  output logic [0:11]      acc_load_data,
  // processor pause control
  output logic             processor_hold,
  output logic             time_state_four_set,
  output logic             arith_done_flag,
  // extension registers
  output logic [2:0]       arith_op_code,
  output logic [0:11]      multiplier_quotient,
  output logic [4:0]       step_counter,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_b;
  logic rst_sync_b;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'h0;
      rst_sync_b <= 1'h0;
    end else begin
      rst_meta_b <= 1'h1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic                       ctrl_en_r;
  logic                       ack_r;
  logic [31:0]                dat_r;
  logic [31:0]                rd_data;
  logic                       acc_load_strobe_r;
  logic                       acc_gate_enable_r;
  logic [0:11]                acc_load_data_r;
  logic                       processor_hold_r;
  logic                       ts4_r;
  logic                       done_flag_r;
  arith_elem_pkg::arith_op_e  op_code_r;
  logic [0:11]                mq_r;
  logic [4:0]                 sc_r;
  arith_elem_pkg::seq_e       state_r;
  logic [5:0]                 div_r;
  logic [9:0]                 min_cnt_r;

  logic        ext_word;
  logic        ext_strobe;
  logic        ext_load;
  logic        tp3_fetch;
  logic        arith_cls;
  logic        regload_cls;
  logic [2:0]  mb_op;
  logic [4:0]  mb_count;
  logic        acc_to_mq_en;
  logic        gate_en;
  logic        mq_en;
  logic        sc_en;
  logic [0:11] acc_next;
  logic        step_tick;
  logic        steps_done;
  logic        min_done;
  logic        arith_start;
  logic        wb_req;
  logic        wb_wr;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic count_loaded(input arith_elem_pkg::arith_op_e op);
    count_loaded = (op == arith_elem_pkg::OP_ARITH_SHR) || (op == arith_elem_pkg::OP_LOGIC_SHR) ||
                   (op == arith_elem_pkg::OP_SHIFT_LEFT) || (op == arith_elem_pkg::OP_STEP_LOAD);
  endfunction

  function automatic logic [4:0] step_limit(input arith_elem_pkg::arith_op_e op);
    step_limit = count_loaded(op) ? arith_elem_pkg::SC_FULL : arith_elem_pkg::SC_MULDIV_STEPS;
  endfunction

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  assign ext_word    = (&memory_buffer_bits[0:3]) & memory_buffer_bits[11];
  assign ext_strobe  = fetch_state & operate_class & memory_buffer_bits[3] &
                       memory_buffer_bits[11] & ctrl_en_r;
  assign ext_load    = ext_strobe & time_pulse_three;
  assign tp3_fetch   = time_pulse_three & fetch_state & operate_class;
  assign mb_op       = {memory_buffer_bits[10], memory_buffer_bits[9],
                        memory_buffer_bits[8]};
  assign mb_count    = memory_buffer_bits[7:11];
  assign regload_cls = ext_word & (((|memory_buffer_bits[4:7]) & ~(|memory_buffer_bits[8:10])) |
                       (mb_op == arith_elem_pkg::OP_STEP_LOAD));
  assign arith_cls   = ext_word & ~(|memory_buffer_bits[4:7]) & (|memory_buffer_bits[8:10]) &
                       (mb_op != arith_elem_pkg::OP_STEP_LOAD);

  // transfer enables, all live during operate phase two of the fetch
  assign acc_to_mq_en = operate_phase_two & memory_buffer_bits[11] &
                        memory_buffer_bits[7] & ~memory_buffer_bits[4];
  assign gate_en      = operate_phase_two & ~memory_buffer_bits[4] & ~acc_to_mq_en;
  assign mq_en        = operate_phase_two & memory_buffer_bits[5] &
                        memory_buffer_bits[11] & regload_cls;
  assign sc_en        = operate_phase_two & memory_buffer_bits[6] &
                        memory_buffer_bits[11] & regload_cls;

  // cleared gate is sequence one, or-ed sources are sequence two
  assign acc_next = (gate_en ? accumulator : 12'h000) |
                    (mq_en ? mq_r : 12'h000) |
                    (sc_en ? {7'h00, sc_r} : 12'h000);

  // ----------------------------------------------------------------
  // accumulator load outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      acc_load_strobe_r <= 1'h0;
      acc_gate_enable_r <= 1'h0;
      acc_load_data_r   <= 12'h000;
    end else begin
      acc_load_strobe_r <= tp3_fetch;
      if (tp3_fetch) begin
        acc_gate_enable_r <= gate_en;
        acc_load_data_r   <= acc_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // op register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      op_code_r <= arith_elem_pkg::OP_NONE;
    end else if (ext_load) begin
      op_code_r <= arith_elem_pkg::arith_op_e'(mb_op);
    end
  end

  // ----------------------------------------------------------------
  // operation sequencer and pause
  // ----------------------------------------------------------------
  assign arith_start = ext_load & arith_cls & (state_r == arith_elem_pkg::ST_IDLE);
  assign step_tick   = (state_r == arith_elem_pkg::ST_RUN) &&
                       (div_r == 6'(arith_elem_pkg::STEP_CYC - 1));
  assign steps_done  = (sc_r == step_limit(op_code_r));
  assign min_done    = (min_cnt_r == 10'(arith_elem_pkg::MIN_OP_CYC));

  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_r <= arith_elem_pkg::ST_IDLE;
    end else begin
      unique case (state_r)
        arith_elem_pkg::ST_IDLE: begin
          if (arith_start) begin
            if (mb_op == arith_elem_pkg::OP_NORMALIZE) begin
              state_r <= arith_elem_pkg::ST_RUN;
            end else begin
              state_r <= arith_elem_pkg::ST_WAIT_EXEC;
            end
          end
        end
        arith_elem_pkg::ST_WAIT_EXEC: begin
          if (execute_state & time_pulse_three) begin
            state_r <= arith_elem_pkg::ST_RUN;
          end
        end
        arith_elem_pkg::ST_RUN: begin
          if (steps_done & min_done) begin
            state_r <= arith_elem_pkg::ST_FINISH;
          end
        end
        arith_elem_pkg::ST_FINISH: begin
          state_r <= arith_elem_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // step pacing and minimum duration
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      div_r     <= 6'h00;
      min_cnt_r <= 10'h000;
    end else if (state_r != arith_elem_pkg::ST_RUN) begin
      div_r     <= 6'h00;
      min_cnt_r <= 10'h000;
    end else begin
      div_r <= step_tick ? 6'h00 : div_r + 6'h01;
      if (!min_done) begin
        min_cnt_r <= min_cnt_r + 10'h001;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      processor_hold_r <= 1'h0;
    end else if (arith_start) begin
      processor_hold_r <= 1'h1;
    end else if (state_r == arith_elem_pkg::ST_FINISH) begin
      processor_hold_r <= 1'h0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ts4_r       <= 1'h0;
      done_flag_r <= 1'h0;
    end else begin
      ts4_r <= (state_r == arith_elem_pkg::ST_RUN) & steps_done & min_done;
      if ((state_r == arith_elem_pkg::ST_RUN) & steps_done & min_done) begin
        done_flag_r <= 1'h1;
      end else if (ext_load) begin
        done_flag_r <= 1'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // multiplier-quotient register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      mq_r <= arith_elem_pkg::MQ_RST;
    end else if (ext_load & memory_buffer_bits[7] & regload_cls) begin
      mq_r <= acc_to_mq_en ? accumulator : arith_elem_pkg::MQ_RST;
    end else if (step_tick & ~steps_done) begin
      unique case (op_code_r)
        arith_elem_pkg::OP_SHIFT_LEFT: mq_r <= {mq_r[1:11], 1'h0};
        arith_elem_pkg::OP_ARITH_SHR,
        arith_elem_pkg::OP_LOGIC_SHR:  mq_r <= {accumulator[11], mq_r[0:10]};
        default:                       mq_r <= mq_r;
      endcase
    end else if ((state_r == arith_elem_pkg::ST_FINISH) &&
                 ((op_code_r == arith_elem_pkg::OP_MULTIPLY) ||
                  (op_code_r == arith_elem_pkg::OP_DIVIDE))) begin
      mq_r <= muldiv_mq_result;
    end else if (wb_wr && (wb_adr_i == arith_elem_pkg::ADR_MQ)) begin
      if (wb_sel_i[1]) begin
        mq_r[0:3] <= wb_dat_i[11:8];
      end
      if (wb_sel_i[0]) begin
        mq_r[4:11] <= wb_dat_i[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // step counter
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sc_r <= arith_elem_pkg::SC_RST;
    end else if (ext_load && (mb_op != arith_elem_pkg::OP_NONE)) begin
      if (count_loaded(arith_elem_pkg::arith_op_e'(mb_op))) begin
        sc_r <= ~mb_count;
      end else begin
        sc_r <= arith_elem_pkg::SC_RST;
      end
    end else if (step_tick & ~steps_done) begin
      sc_r <= sc_r + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  assign wb_req = wb_cyc_i & wb_stb_i;
  assign wb_wr  = wb_req & ack_r & wb_we_i;

  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (wb_adr_i)
      arith_elem_pkg::ADR_CTRL:   rd_data[arith_elem_pkg::CTRL_EN_BIT] = ctrl_en_r;
      arith_elem_pkg::ADR_STATUS: begin
        rd_data[arith_elem_pkg::STAT_HOLD_BIT] = processor_hold_r;
        rd_data[arith_elem_pkg::STAT_RUN_BIT]  = (state_r == arith_elem_pkg::ST_RUN);
        rd_data[arith_elem_pkg::STAT_DONE_BIT] = done_flag_r;
        rd_data[arith_elem_pkg::STAT_OP_LSB +: 3] = op_code_r;
      end
      arith_elem_pkg::ADR_MQ:     rd_data[11:0] = mq_r;
      arith_elem_pkg::ADR_SC:     rd_data[4:0]  = sc_r;
      default:                    rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ack_r <= 1'h0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= wb_req & ~ack_r;
      if (wb_req & ~ack_r) begin
        dat_r <= rd_data;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ctrl_en_r <= arith_elem_pkg::CTRL_EN_RST;
    end else if (wb_wr && (wb_adr_i == arith_elem_pkg::ADR_CTRL) && wb_sel_i[0]) begin
      ctrl_en_r <= wb_dat_i[arith_elem_pkg::CTRL_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign acc_load_strobe     = acc_load_strobe_r;
  assign acc_gate_enable     = acc_gate_enable_r;
  assign acc_load_data       = acc_load_data_r;
  assign processor_hold      = processor_hold_r;
  assign time_state_four_set = ts4_r;
  assign arith_done_flag     = done_flag_r;
  assign arith_op_code       = op_code_r;
  assign multiplier_quotient = mq_r;
  assign step_counter        = sc_r;
  assign wb_dat_o            = dat_r;
  assign wb_ack_o            = ack_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  localparam int HOLD_MIN = arith_elem_pkg::MIN_OP_CYC;
  logic [11:0] hold_cnt_r;

  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      hold_cnt_r <= 12'h000;
    end else if (!processor_hold_r) begin
      hold_cnt_r <= 12'h000;
    end else if (hold_cnt_r != 12'hFFF) begin
      hold_cnt_r <= hold_cnt_r + 12'h001;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_sync_b);

  sequence fetch_arith_s;
    arith_start;
  endsequence

  sequence finish_s;
    (state_r == arith_elem_pkg::ST_RUN) ##1 (state_r == arith_elem_pkg::ST_FINISH);
  endsequence

  chk_hold_start: assert property (fetch_arith_s |=> processor_hold_r)
    else $error("hold not raised after arithmetic fetch");
  chk_exec_wait: assert property ((state_r == arith_elem_pkg::ST_WAIT_EXEC) &&
      !(execute_state && time_pulse_three) |=> (state_r == arith_elem_pkg::ST_WAIT_EXEC))
    else $error("run started without execute cycle");
  chk_hold_min: assert property ($fell(processor_hold_r) |-> (hold_cnt_r > HOLD_MIN))
    else $error("hold shorter than minimum operation time");
  chk_done_ts4: assert property (finish_s |-> time_state_four_set && arith_done_flag
      ##1 !processor_hold_r && !time_state_four_set)
    else $error("finish did not raise time state four and end hold");
  chk_ir_load: assert property (ext_load |=> (op_code_r == $past(mb_op)))
    else $error("op register did not take bits 08 to 10");
  chk_ir_strobe: assert property ((op_code_r != $past(op_code_r)) |-> $past(ext_load))
    else $error("op register changed without instruction strobe");
  chk_sc_load: assert property (ext_load && count_loaded(arith_elem_pkg::arith_op_e'(mb_op))
      |=> (sc_r == ~$past(mb_count)))
    else $error("step counter not loaded with complement");
  chk_sc_stops: assert property ((state_r == arith_elem_pkg::ST_RUN) && steps_done
      |=> (sc_r == $past(sc_r)))
    else $error("step counter moved after shifts done");
  chk_acc_clear: assert property (tp3_fetch && memory_buffer_bits[4] && !mq_en && !sc_en
      |=> acc_load_strobe && (acc_load_data == 12'h000) && !acc_gate_enable)
    else $error("clear accumulator did not zero the load");
  chk_cam_clear: assert property (ext_load && regload_cls && memory_buffer_bits[4] &&
      memory_buffer_bits[7] |=> (mq_r == arith_elem_pkg::MQ_RST))
    else $error("mq not cleared");
  chk_mq_or: assert property (tp3_fetch && mq_en && !gate_en && !sc_en
      |=> (acc_load_data == $past(mq_r)))
    else $error("mq not transferred to accumulator");
  chk_mql_copy: assert property (ext_load && regload_cls && acc_to_mq_en && !mq_en && !sc_en
      |=> (mq_r == $past(accumulator)) && (acc_load_data == 12'h000))
    else $error("accumulator not moved into mq");

endmodule // arith_element_decode_ctrl

// ### arith_elem_pkg.sv
// shared constants and types for the arithmetic extension decode block
package arith_elem_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int STEP_PERIOD_NS = 350;
  localparam int STEP_CYC       = STEP_PERIOD_NS / CLK_PERIOD_NS;
  localparam int MIN_OP_TIME_NS = 7800;
  localparam int MIN_OP_CYC     = (MIN_OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [3:0] ADR_CTRL   = 4'h0;
  localparam logic [3:0] ADR_STATUS = 4'h4;
  localparam logic [3:0] ADR_MQ     = 4'h8;
  localparam logic [3:0] ADR_SC     = 4'hC;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int   CTRL_EN_BIT   = 0;
  localparam logic CTRL_EN_RST   = 1'h1;
  localparam int   STAT_HOLD_BIT = 0;
  localparam int   STAT_RUN_BIT  = 1;
  localparam int   STAT_DONE_BIT = 2;
  localparam int   STAT_OP_LSB   = 4;

  localparam logic [11:0] MQ_RST          = 12'h000;
  localparam logic [4:0]  SC_RST          = 5'h00;
  localparam logic [4:0]  SC_FULL         = 5'h1F;
  localparam logic [4:0]  SC_MULDIV_STEPS = 5'h0C;

  // ----------------------------------------------------------------
  // operation codes held in the 3-bit op register
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE       = 3'b000,
    OP_NORMALIZE  = 3'b001,
    OP_MULTIPLY   = 3'b010,
    OP_ARITH_SHR  = 3'b011,
    OP_STEP_LOAD  = 3'b100,
    OP_SHIFT_LEFT = 3'b101,
    OP_DIVIDE     = 3'b110,
    OP_LOGIC_SHR  = 3'b111
  } arith_op_e;

  // ----------------------------------------------------------------
  // operation sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE      = 2'b00,
    ST_WAIT_EXEC = 2'b01,
    ST_RUN       = 2'b10,
    ST_FINISH    = 2'b11
  } seq_e;

endpackage

// ### proc_model.sv
// processor timing model issuing fetch and execute cycles
module proc_model (
  // clock and pause
  input  wire logic   ref_clk,
  input  wire logic   processor_hold,
  // timing states and word
  output logic        fetch_state,
  output logic        execute_state,
  output logic        operate_class,
  output logic        operate_phase_two,
  output logic        time_pulse_three,
  output logic [0:11] memory_buffer_bits,
  output logic [0:11] accumulator
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {fetch_state, execute_state, operate_class, operate_phase_two} = 4'h0;
  initial {time_pulse_three, memory_buffer_bits, accumulator} = 25'h0;
  // states first, pulse three a cycle later, then the word is released
  task automatic cyc(input logic f, input logic [0:11] w, input logic [0:11] a);
    @(posedge ref_clk);
    {fetch_state, execute_state, operate_class, operate_phase_two} <= {f, !f, 1'b1, f};
    {memory_buffer_bits, accumulator} <= {w, a};
    @(posedge ref_clk);
    time_pulse_three <= 1'b1;
    @(posedge ref_clk);
    {time_pulse_three, fetch_state, execute_state, operate_phase_two} <= 4'h0;
    memory_buffer_bits <= ~w;
  endtask
  // operand cycle follows a pausing op unless it normalizes
  task automatic fetch(input logic [0:11] w, input logic [0:11] a);
    cyc(1'b1, w, a);
    #1;
    if (processor_hold === 1'b1 && {w[10], w[9], w[8]} != 3'h1) begin
      cyc(1'b0, 12'h003, a);
    end
  endtask
endmodule // proc_model

// ### tb_top.sv
// self-checking bench for the arithmetic extension decode block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        fetch_state, execute_state, operate_class, operate_phase_two, time_pulse_three;
  logic [0:11] memory_buffer_bits, accumulator, acc_load_data, multiplier_quotient;
  logic        acc_load_strobe, acc_gate_enable, processor_hold, time_state_four_set;
  logic        arith_done_flag, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [2:0]  arith_op_code;
  logic [4:0]  step_counter;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  int          errors = 0;
  int          checks = 0;
  always #5 ref_clk = ~ref_clk;
  proc_model i_proc (.ref_clk, .processor_hold, .fetch_state, .execute_state, .operate_class,
    .operate_phase_two, .time_pulse_three, .memory_buffer_bits, .accumulator);
  arith_element_decode_ctrl i_dut (.ref_clk, .rst_b, .fetch_state, .execute_state,
    .operate_class, .operate_phase_two, .time_pulse_three, .memory_buffer_bits, .accumulator,
    .muldiv_mq_result(12'hA5C), .acc_load_strobe, .acc_gate_enable, .acc_load_data,
    .processor_hold, .time_state_four_set, .arith_done_flag, .arith_op_code,
    .multiplier_quotient, .step_counter, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("Error %0t: saw %h want %h", $time, s, e);
    end
  endtask
  // classic single wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, w, a, 4'hF, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    if (wb_ack_o !== 1'b1) begin
      errors++;
      give_verdict();
    end
  endtask
  task automatic t_regs;
    wb(1'b0, arith_elem_pkg::ADR_CTRL, 32'h0);
    chk(rd, 32'h1);
    wb(1'b1, arith_elem_pkg::ADR_MQ, 32'hABC);
    wb(1'b0, arith_elem_pkg::ADR_MQ, 32'h0);
    chk(rd, 32'hABC);
    wb(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h0);
    $display("register test done");
  endtask
  task automatic xf(input logic [0:11] w, a, d, input logic g);
    i_proc.fetch(w, a);
    chk(acc_load_strobe, 1'b1);
    chk(acc_load_data, d);
    chk(acc_gate_enable, g);
  endtask
  task automatic t_xfer;
    xf(12'hF41, 12'h301, 12'hBBD, 1'b1);
    chk(arith_op_code, 3'h0);
    xf(12'hFC1, 12'h301, 12'hABC, 1'b0);
    xf(12'hF11, 12'h123, 12'h000, 1'b0);
    chk(multiplier_quotient, 12'h123);
    xf(12'hF91, 12'h555, 12'h000, 1'b0);
    chk(multiplier_quotient, 12'h000);
    i_proc.fetch(12'hF03, 12'h000);
    chk({arith_op_code, step_counter, processor_hold}, {3'h4, 5'h1C, 1'b0});
    i_proc.fetch(12'hF08, 12'h000);
    chk({arith_op_code, processor_hold}, 4'h8);
    xf(12'hFA1, 12'h700, 12'h01C, 1'b0);
    $display("transfer test done");
  endtask
  task automatic t_op(input logic [0:11] w, a, mq, input logic [2:0] op, input logic [4:0] sc);
    int n;
    n = 0;
    i_proc.fetch(w, a);
    chk({processor_hold, arith_op_code, step_counter}, {1'b1, op, sc});
    while (time_state_four_set !== 1'b1 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    chk(n >= arith_elem_pkg::MIN_OP_CYC, 1'b1);
    if (n == 3000) begin
      errors++;
      give_verdict();
    end
    chk(arith_done_flag, 1'b1);
    #1;
    chk(processor_hold, 1'b0);
    chk(step_counter, (op == 3'h3) ? arith_elem_pkg::SC_FULL
                                   : arith_elem_pkg::SC_MULDIV_STEPS);
    if (op != 3'h1) chk(multiplier_quotient, mq);
    $display("op test done");
  endtask
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = 43'h0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_regs();
    t_xfer();
    t_op(12'hF05, 12'h000, 12'hA5C, 3'h2, 5'h00);
    t_op(12'hF09, 12'h000, 12'h000, 3'h1, 5'h00);
    t_op(12'hF0D, 12'hFFF, 12'hFFF, 3'h3, 5'h12);
    give_verdict();
  end
endmodule // tb_top
